// File: acd_pkg.sv
/*
 * audio clock detector package: register map, field positions, detector timing and the master-clock ratio table.
 * assumes a 100 MHz system clock and a word-wide AHB-Lite register bus.
 */
package acd_pkg;

	// ****************************************
	// register map (word index, byte address = index * 4)
	// ****************************************
	localparam logic [9:0] STATUS_IDX = 10'h05E;
	localparam logic [9:0] IGNORE_IDX = 10'h025;
	localparam logic [9:0] EVENT_IDX = 10'h060;
	localparam logic [9:0] MASK_IDX = 10'h061;
	localparam int ADDR_W = 12;

	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] IGNORE_RESET = 8'h00;
	localparam logic [7:0] EVENT_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [6:0] IGNORE_ALL = 7'h7F;

	// ****************************************
	// status field positions
	// ****************************************
	localparam int BIT_RESERVED = 7;
	localparam int BIT_MCLK_HALT = 6;
	localparam int BIT_PLL_LOCK = 5;
	localparam int BIT_PINS_ABSENT = 4;
	localparam int BIT_COMBO_BAD = 3;
	localparam int BIT_MCLK_BAD = 2;
	localparam int BIT_BCLK_BAD = 1;
	localparam int BIT_RATE_BAD = 0;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 100000000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MCLK_HALT_NS = 1000;
	localparam int MCLK_HALT_CYC = (MCLK_HALT_NS / CLK_PERIOD_NS < 1) ? 1 : MCLK_HALT_NS / CLK_PERIOD_NS;
	localparam int ABSENT_NS = 20000;
	localparam int ABSENT_CYC = (ABSENT_NS / CLK_PERIOD_NS < 1) ? 1 : ABSENT_NS / CLK_PERIOD_NS;
	localparam int FS_MAX_HZ = 192000;
	localparam int FS_MIN_HZ = 8000;
	localparam int FRAME_MIN_CYC = CLK_HZ / FS_MAX_HZ;
	localparam int FRAME_TIMEOUT_CYC = CLK_HZ / FS_MIN_HZ;

	// ****************************************
	// detector limits
	// ****************************************
	localparam int LOW_PHASE_MIN_BCLK = 5;
	localparam int BCLK_RATIO_MIN = 32;
	localparam int BCLK_RATIO_MAX = 256;
	localparam int MIN_RATIO_NOPLL = 128;
	localparam int RATIO_ENTRIES = 14;
	localparam logic [RATIO_ENTRIES-1:0][11:0] RATIO_TAB = {
		12'hC00, 12'h800, 12'h600, 12'h480, 12'h400, 12'h300, 12'h200,
		12'h180, 12'h100, 12'h0C0, 12'h080, 12'h040, 12'h030, 12'h020
	};

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} acd_ahb_req_type;

	typedef struct packed {
		logic mclk;
		logic bit_clk;
		logic frame_sync_input;
	} acd_pins_type;

	// ratio code: entry index + 1, zero when the count matches no entry
	function automatic logic [3:0] acd_ratio_code(input logic [12:0] cnt);
		logic [3:0] code;
		code = 4'h0;
		for (int i = 0; i < RATIO_ENTRIES; i++) begin
			if (cnt == {1'b0, RATIO_TAB[i]}) begin
				code = 4'(i + 1);
			end
		end
		return code;
	endfunction : acd_ratio_code

endpackage : acd_pkg

// File: acd_top.sv
/*
 * audio clock detector status: watches the master, bit and frame clocks of the audio serial input and reports
 * their health in a read-only status register, with sticky change events, a mask and one interrupt line.
 * assumes the clock pins arrive asynchronously, the PLL lock comes from analog logic, and the bus is AHB-Lite.
 */
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module acd_top #(
	parameter int FRAME_TIMEOUT_CYC = acd_pkg::FRAME_TIMEOUT_CYC,
	parameter int MIN_RATIO_NOPLL = acd_pkg::MIN_RATIO_NOPLL
) (
	input wire logic clk,
	input wire logic nrst,
	input wire acd_pkg::acd_ahb_req_type ahb_req,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire acd_pkg::acd_pins_type pins,
	input wire logic pll_enable,
	input wire logic pll_locked,
	output logic irq
);
	import acd_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [2:0] mclk_sync;
		logic [2:0] bclk_sync;
		logic [2:0] fs_sync;
		logic [1:0] lock_sync;
		logic [15:0] mclk_idle;
		logic [15:0] pin_idle;
		logic [15:0] frame_cnt;
		logic [9:0] bclk_cnt;
		logic [12:0] mclk_cnt;
		logic [9:0] low_bclk;
		logic [9:0] prev_bclk;
		logic [1:0] frames_seen;
		logic rate_bad;
		logic bclk_bad;
		logic mclk_bad;
		logic combo_bad;
		logic [7:0] status;
		logic [7:0] ignore_cfg;
		logic [7:0] events;
		logic [7:0] mask;
		logic ap_valid;
		logic ap_write;
		logic [9:0] ap_idx;
		logic [31:0] rdata;
		logic ready;
		logic irq;
	} acd_state_type;

	acd_state_type s_q;
	acd_state_type s_d;

	logic mclk_rise;
	logic bclk_rise;
	logic fs_rise;
	logic fs_fall;
	logic pins_absent;
	logic [3:0] ratio_code;
	logic ignore_all;
	logic [31:0] read_word;
	logic addr_ok;
	logic [9:0] rd_idx;

	localparam logic [15:0] HALT_LIMIT = 16'(MCLK_HALT_CYC);
	localparam logic [15:0] ABSENT_LIMIT = 16'(ABSENT_CYC);
	localparam logic [15:0] FRAME_MIN = 16'(FRAME_MIN_CYC);
	localparam logic [15:0] FRAME_TIMEOUT = 16'(FRAME_TIMEOUT_CYC);
	localparam logic [12:0] NOPLL_MIN = 13'(MIN_RATIO_NOPLL);
	localparam logic [9:0] LOW_MIN = 10'(LOW_PHASE_MIN_BCLK);
	localparam logic [9:0] BCLK_MIN = 10'(BCLK_RATIO_MIN);
	localparam logic [9:0] BCLK_MAX = 10'(BCLK_RATIO_MAX);

	// ****************************************
	// edge detection on synchronised pins
	// ****************************************
	assign mclk_rise = s_q.mclk_sync[1] & ~s_q.mclk_sync[2];
	assign bclk_rise = s_q.bclk_sync[1] & ~s_q.bclk_sync[2];
	assign fs_rise = s_q.fs_sync[1] & ~s_q.fs_sync[2];
	assign fs_fall = ~s_q.fs_sync[1] & s_q.fs_sync[2];
	assign pins_absent = (s_q.pin_idle >= ABSENT_LIMIT);
	assign ratio_code = acd_ratio_code(s_q.mclk_cnt);
	assign ignore_all = (s_q.ignore_cfg[6:0] == IGNORE_ALL);
	assign addr_ok = (ahb_req.haddr[1:0] == 2'h0) && (ahb_req.haddr[31:ADDR_W] == '0);
	assign rd_idx = addr_ok ? ahb_req.haddr[ADDR_W-1:2] : 10'h3FF;

	// ****************************************
	// register read mux
	// ****************************************
	always_comb begin
		// decodes the address phase so the word stands on hrdata for the whole data phase
		read_word = 32'h0000_0000;
		if (rd_idx == STATUS_IDX) begin
			read_word = {24'h000000, s_q.status};
		end else if (rd_idx == IGNORE_IDX) begin
			read_word = {24'h000000, s_q.ignore_cfg};
		end else if (rd_idx == EVENT_IDX) begin
			read_word = {24'h000000, s_q.events};
		end else if (rd_idx == MASK_IDX) begin
			read_word = {24'h000000, s_q.mask};
		end
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_d = s_q;

		// two-flop synchronisers, third flop for edge detection
		s_d.mclk_sync = {s_q.mclk_sync[1:0], pins.mclk};
		s_d.bclk_sync = {s_q.bclk_sync[1:0], pins.bit_clk};
		s_d.fs_sync = {s_q.fs_sync[1:0], pins.frame_sync_input};
		s_d.lock_sync = {s_q.lock_sync[0], pll_locked};

		// master clock activity watchdog
		if (mclk_rise) begin
			s_d.mclk_idle = 16'h0000;
		end else if (s_q.mclk_idle != 16'hFFFF) begin
			s_d.mclk_idle = s_q.mclk_idle + 16'h0001;
		end

		// idle time of frame and bit clocks, counted only while both sit low
		if (s_q.fs_sync[1] || s_q.bclk_sync[1]) begin
			s_d.pin_idle = 16'h0000;
		end else if (s_q.pin_idle != 16'hFFFF) begin
			s_d.pin_idle = s_q.pin_idle + 16'h0001;
		end

		// per-frame measurement
		if (s_q.frame_cnt != 16'hFFFF) begin
			s_d.frame_cnt = s_q.frame_cnt + 16'h0001;
		end
		if (bclk_rise && s_q.bclk_cnt != 10'h3FF) begin
			s_d.bclk_cnt = s_q.bclk_cnt + 10'h001;
		end
		if (mclk_rise && s_q.mclk_cnt != 13'h1FFF) begin
			s_d.mclk_cnt = s_q.mclk_cnt + 13'h0001;
		end
		if (fs_fall) begin
			s_d.low_bclk = 10'h000;
		end else if (bclk_rise && !s_q.fs_sync[2] && s_q.low_bclk != 10'h3FF) begin
			s_d.low_bclk = s_q.low_bclk + 10'h001;
		end

		if (fs_rise) begin
			s_d.frame_cnt = 16'h0000;
			s_d.bclk_cnt = 10'h000;
			s_d.mclk_cnt = 13'h0000;
			s_d.prev_bclk = s_q.bclk_cnt;
			if (s_q.frames_seen != 2'h3) begin
				s_d.frames_seen = s_q.frames_seen + 2'h1;
			end
			s_d.rate_bad = (s_q.frames_seen == 2'h0) || (s_q.frame_cnt < FRAME_MIN);
			s_d.bclk_bad = (s_q.frames_seen < 2'h2) || (s_q.bclk_cnt != s_q.prev_bclk) ||
				(s_q.bclk_cnt < BCLK_MIN) || (s_q.bclk_cnt > BCLK_MAX);
			s_d.mclk_bad = (ratio_code == 4'h0) ||
				(s_q.low_bclk <= LOW_MIN);
			s_d.combo_bad = (ratio_code == 4'h0) || (s_q.frames_seen == 2'h0) ||
				(s_q.frame_cnt < FRAME_MIN) || (!pll_enable && s_q.mclk_cnt < NOPLL_MIN);
		end else if (s_q.frame_cnt >= FRAME_TIMEOUT) begin
			// no frame edge for longer than the slowest rate allows
			s_d.frames_seen = 2'h0;
			s_d.rate_bad = 1'b1;
			s_d.bclk_bad = 1'b1;
			s_d.mclk_bad = 1'b1;
			s_d.combo_bad = 1'b1;
		end

		// live status word
		s_d.status[BIT_RESERVED] = 1'b0;
		s_d.status[BIT_MCLK_HALT] = (s_q.mclk_idle >= HALT_LIMIT);
		s_d.status[BIT_PLL_LOCK] = pll_enable & s_q.lock_sync[1];
		s_d.status[BIT_PINS_ABSENT] = pins_absent & ~s_q.fs_sync[1] & ~s_q.bclk_sync[1];
		s_d.status[BIT_COMBO_BAD] = s_q.combo_bad;
		s_d.status[BIT_MCLK_BAD] = s_q.mclk_bad;
		s_d.status[BIT_BCLK_BAD] = s_q.bclk_bad;
		s_d.status[BIT_RATE_BAD] = s_q.rate_bad & ~ignore_all;

		// ****************************************
		// AHB-Lite slave, zero wait states
		// ****************************************
		s_d.ready = 1'b1;
		if (s_q.ap_valid && s_q.ap_write) begin
			if (s_q.ap_idx == IGNORE_IDX) begin
				s_d.ignore_cfg = ahb_req.hwdata[7:0];
			end else if (s_q.ap_idx == EVENT_IDX) begin
				s_d.events = s_q.events & ~ahb_req.hwdata[7:0];
			end else if (s_q.ap_idx == MASK_IDX) begin
				s_d.mask = ahb_req.hwdata[7:0];
			end
			// the status index takes no write: it always mirrors the detectors
		end

		// change events: set after the clear so a coincident set wins
		s_d.events = s_d.events | (s_d.status ^ s_q.status);
		s_d.events[BIT_RESERVED] = 1'b0;
		s_d.irq = |(s_d.events & s_d.mask);

		s_d.ap_valid = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
		s_d.ap_write = ahb_req.hwrite;
		s_d.ap_idx = rd_idx;
		s_d.rdata = 32'h0000_0000;
		if (s_d.ap_valid && !ahb_req.hwrite) begin
			s_d.rdata = read_word;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.status <= STATUS_RESET;
			s_q.ignore_cfg <= IGNORE_RESET;
			s_q.events <= EVENT_RESET;
			s_q.mask <= MASK_RESET;
			s_q.ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign hrdata = s_q.rdata;
	assign hreadyout = s_q.ready;
	assign hresp = 1'b0;
	assign irq = s_q.irq;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	reserved_zero_a: assert property (s_q.status[BIT_RESERVED] == 1'b0)
		else $error("reserved status bit is set");

	halt_flag_a: assert property ((s_q.mclk_idle >= HALT_LIMIT) |=> s_q.status[BIT_MCLK_HALT])
		else $error("halted master clock not reported");

	halt_clear_a: assert property (mclk_rise |=> ##1 !s_q.status[BIT_MCLK_HALT])
		else $error("running master clock reported halted");

	pll_off_a: assert property (!pll_enable |=> !s_q.status[BIT_PLL_LOCK])
		else $error("disabled pll reported locked");

	absent_toggle_a: assert property ((s_q.fs_sync[1] || s_q.bclk_sync[1]) |=> !s_q.status[BIT_PINS_ABSENT])
		else $error("absent flag set while a clock is high");

	absent_set_a: assert property ((s_q.pin_idle >= ABSENT_LIMIT && !s_q.fs_sync[1] && !s_q.bclk_sync[1])
		|=> s_q.status[BIT_PINS_ABSENT])
		else $error("both clocks low but absent flag clear");

	combo_nopll_a: assert property ((fs_rise && !pll_enable && s_q.mclk_cnt < NOPLL_MIN)
		|=> ##1 s_q.status[BIT_COMBO_BAD])
		else $error("low ratio without pll not flagged");

	low_phase_a: assert property ((fs_rise && s_q.low_bclk <= LOW_MIN) |=> ##1 s_q.status[BIT_MCLK_BAD])
		else $error("short frame low phase not flagged");

	ratio_miss_a: assert property ((fs_rise && ratio_code == 4'h0) |=> ##1 s_q.status[BIT_MCLK_BAD])
		else $error("undetected ratio not flagged");

	bclk_range_a: assert property ((fs_rise && s_q.bclk_cnt > BCLK_MAX) |=> ##1 s_q.status[BIT_BCLK_BAD])
		else $error("bit clock ratio over range not flagged");

	rate_timeout_a: assert property ((!fs_rise && s_q.frame_cnt >= FRAME_TIMEOUT && !ignore_all)
		|=> ##1 (s_q.status[BIT_RATE_BAD] || ignore_all))
		else $error("missing frames not flagged as bad rate");

	ignore_all_a: assert property (ignore_all |=> !s_q.status[BIT_RATE_BAD])
		else $error("rate flag shown while all errors ignored");

	status_ro_a: assert property ((s_q.ap_valid && !s_q.ap_write && s_q.ap_idx == STATUS_IDX)
		|-> hrdata == {24'h000000, $past(s_q.status)})
		else $error("status readback differs from live state");

	irq_level_a: assert property (|(s_q.events & s_q.mask) |-> s_q.irq)
		else $error("interrupt low with unmasked event pending");

	// detector reporting, both directions
	lock_shown_a: assert property ((pll_enable && s_q.lock_sync[1]) |=> s_q.status[BIT_PLL_LOCK])
		else $error("locked pll reported unlocked");

	lock_lost_a: assert property (!s_q.lock_sync[1] |=> !s_q.status[BIT_PLL_LOCK])
		else $error("unlocked pll reported locked");

	halt_wait_a: assert property ((s_q.mclk_idle < HALT_LIMIT) |=> !s_q.status[BIT_MCLK_HALT])
		else $error("master clock reported halted too early");

	ratio_hit_a: assert property ((fs_rise && ratio_code != 4'h0 && s_q.low_bclk > LOW_MIN)
		|=> ##1 !s_q.status[BIT_MCLK_BAD])
		else $error("detected ratio flagged invalid");

	bclk_unstable_a: assert property ((fs_rise && s_q.bclk_cnt != s_q.prev_bclk)
		|=> ##1 s_q.status[BIT_BCLK_BAD])
		else $error("changing bit clock count not flagged");

	bclk_short_a: assert property ((fs_rise && s_q.bclk_cnt < BCLK_MIN)
		|=> ##1 s_q.status[BIT_BCLK_BAD])
		else $error("bit clock ratio under range not flagged");

	bclk_good_a: assert property ((fs_rise && s_q.frames_seen >= 2'h2 && s_q.bclk_cnt == s_q.prev_bclk
		&& s_q.bclk_cnt >= BCLK_MIN && s_q.bclk_cnt <= BCLK_MAX) |=> ##1 !s_q.status[BIT_BCLK_BAD])
		else $error("steady in-range bit clock flagged invalid");

	rate_short_a: assert property ((fs_rise && s_q.frame_cnt < FRAME_MIN) |=> s_q.rate_bad)
		else $error("too short frame not flagged as bad rate");

	rate_good_a: assert property ((fs_rise && s_q.frames_seen != 2'h0 && s_q.frame_cnt >= FRAME_MIN)
		|=> !s_q.rate_bad)
		else $error("steady frame rate flagged invalid");

	// bus side: events follow every status change, read data only in its data phase
	event_set_a: assert property ((s_q.status ^ $past(s_q.status)) != 8'h00
		|-> (s_q.events & (s_q.status ^ $past(s_q.status))) == (s_q.status ^ $past(s_q.status)))
		else $error("status change did not raise its event");

	hrdata_idle_a: assert property ((!s_q.ap_valid || s_q.ap_write) |-> hrdata == 32'h0000_0000)
		else $error("read data outside a read data phase");

	irq_masked_a: assert property ((s_q.mask == 8'h00 && !(s_q.ap_valid && s_q.ap_write)) |=> !irq)
		else $error("interrupt raised with every event masked");

endmodule : acd_top

// File: acd_src_model.sv
/*
 * audio source model: drives the master, bit and frame clocks of the serial input.
 * assumes the bench sets the frame length, the low phase and the master clocks per bit clock.
 */
`timescale 1ns/1ps
module acd_src_model (
	input wire logic run,
	input wire logic mclk_on,
	input wire logic [31:0] n_bclk,
	input wire logic [31:0] n_low,
	input wire logic [31:0] k,
	output acd_pkg::acd_pins_type pins
);
	import acd_pkg::*;
	// ****************************************
	// clock generation
	// ****************************************
	// master clock edges are locked to the bit clock so every frame holds the same count
	initial begin
		pins = '0;
		forever begin
			if (run) begin
				for (int b = 0; b < n_bclk; b++) begin
					pins.frame_sync_input = (b >= n_low);
					for (int h = 0; h < 2 * k; h++) begin
						pins.bit_clk = (h >= k);
						pins.mclk = mclk_on & h[0];
						#(62.5 / k);
					end
				end
			end else begin
				// serial clocks stand still low between runs
				pins.bit_clk = 1'b0;
				pins.frame_sync_input = 1'b0;
				pins.mclk = mclk_on & ~pins.mclk;
				#62.5;
			end
		end
	end
endmodule : acd_src_model

// File: audio_clock_detector_status_bench.sv
/*
 * bench for the clock detector status block: corner and random clock patterns, registers and interrupt.
 * assumes the package, the design and the source model are compiled first.
 */
`timescale 1ns/1ps
module audio_clock_detector_status_bench;
	import acd_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	logic pe = 1'b0;
	logic pl = 1'b0;
	logic run = 1'b0;
	logic mon = 1'b0;
	logic ig = 1'b0;
	logic [31:0] nb = 32'd64;
	logic [31:0] nl = 32'd32;
	logic [31:0] kk = 32'd1;
	logic [31:0] rd;
	logic [15:0] ec;
	int pick[5] = '{48, 64, 96, 128, 192};
	int b;
	int mismatches = 0;
	int n_compared = 0;
	acd_pins_type pins;
	acd_ahb_req_type req;

	assign req = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, hreadyout};
	always #5 clk = ~clk;

	acd_top #(.FRAME_TIMEOUT_CYC(4000), .MIN_RATIO_NOPLL(128)) u_acd_top (.clk(clk), .nrst(nrst), .ahb_req(req),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .pll_enable(pe), .pll_locked(pl),
		.irq(irq));
	acd_src_model u_acd_src_model (.run(run), .mclk_on(mon), .n_bclk(nb), .n_low(nl), .k(kk), .pins(pins));

	// ****************************************
	// helpers
	// ****************************************
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] care);
		n_compared++;
		if ((got & care) !== (exp & care)) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// samples just before the rising edge, which is what that edge sees
	task automatic phase(output logic [31:0] d);
		logic ok;
		for (int n = 0; n < 40; n++) begin
			@(negedge clk);
			ok = hreadyout;
			d = hrdata;
			@(posedge clk);
			if (ok === 1'b1) return;
		end
		mismatches++;
		results();
	endtask : phase

	function automatic logic [31:0] a(input logic [9:0] idx);
		return {20'h0, idx, 2'b00};
	endfunction : a

	task automatic bus(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
		logic [31:0] d;
		hsel <= 1'b1;
		haddr <= ad;
		htrans <= 2'b10;
		hwrite <= wr;
		phase(d);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		phase(rd);
	endtask : bus

	// upper byte is the care mask, lower byte the expected status
	function automatic logic [15:0] expect_st(input logic r, input logic m, input int nb2, input int l, input int k2,
		input logic e, input logic p, input logic ign);
		logic [7:0] ex;
		logic [7:0] c;
		int ra;
		ra = nb2 * k2;
		c = 8'hFF;
		ex = 8'h00;
		ex[6] = !m;
		ex[5] = e & p;
		if (!r) begin
			ex[4:0] = 5'h1F;
		end else begin
			ex[2] = !m || !(ra inside {32, 48, 64, 128, 192, 256, 384, 512, 768, 1024, 1152, 1536, 2048, 3072}) || l <= 5;
			ex[1] = nb2 < 32 || nb2 > 256;
			ex[0] = nb2 < 42;
			c[3] = !(ex[2] | ex[1] | ex[0]);
			ex[3] = c[3] & (ra < 128) & !e;
		end
		if (ign) ex[0] = 1'b0;
		return {c, ex};
	endfunction : expect_st

	task automatic scen(input logic r, input logic m, input int nb2, input int l, input int k2, input logic e,
		input logic p);
		run <= r;
		mon <= m;
		nb <= nb2;
		nl <= l;
		kk <= k2;
		pe <= e;
		pl <= p;
		repeat (r ? 38 * nb2 + 13 * l + 1200 : 5000) @(posedge clk);
		ec = expect_st(r, m, nb2, l, k2, e, p, ig);
		bus(1'b0, a(STATUS_IDX), '0);
		cmp(rd, {24'h0, ec[7:0]}, {24'hFFFFFF, ec[15:8]});
		$display("test done status=%h", rd[7:0]);
	endtask : scen

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(91));
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		bus(1'b0, a(IGNORE_IDX), '0);
		cmp(rd, {24'h0, IGNORE_RESET}, '1);
		bus(1'b0, a(MASK_IDX), '0);
		cmp(rd, {24'h0, MASK_RESET}, '1);
		cmp({31'h0, hresp}, '0, 32'h1);
		scen(1, 1, 64, 32, 2, 1, 1);
		scen(1, 1, 64, 32, 2, 1, 0);
		scen(1, 1, 64, 32, 1, 0, 1);
		scen(1, 1, 64, 5, 2, 1, 1);
		scen(1, 1, 64, 6, 2, 1, 1);
		scen(1, 1, 256, 128, 1, 1, 1);
		scen(1, 1, 300, 100, 1, 1, 1);
		scen(1, 1, 32, 16, 1, 1, 1);
		ig = 1'b1;
		bus(1'b1, a(IGNORE_IDX), 32'h7F);
		scen(1, 1, 32, 16, 1, 1, 1);
		ig = 1'b0;
		bus(1'b1, a(IGNORE_IDX), '0);
		scen(1, 0, 64, 32, 2, 1, 1);
		scen(0, 1, 64, 32, 2, 1, 1);
		scen(0, 0, 64, 32, 2, 0, 0);
		bus(1'b1, a(STATUS_IDX), 32'hFF);
		bus(1'b0, a(STATUS_IDX), '0);
		cmp(rd, {24'h0, ec[7:0]}, '1);
		bus(1'b0, 32'h0000_1178, '0);
		cmp(rd, '0, '1);
		scen(1, 1, 64, 32, 2, 1, 1);
		bus(1'b1, a(EVENT_IDX), 32'hFF);
		bus(1'b1, a(MASK_IDX), 32'h40);
		repeat (3) @(posedge clk);
		cmp({31'h0, irq}, '0, 32'h1);
		mon <= 1'b0;
		repeat (300) @(posedge clk);
		cmp({31'h0, irq}, 32'h1, 32'h1);
		bus(1'b0, a(EVENT_IDX), '0);
		cmp(rd, 32'h40, 32'h40);
		bus(1'b1, a(EVENT_IDX), 32'h40);
		repeat (3) @(posedge clk);
		cmp({31'h0, irq}, '0, 32'h1);
		bus(1'b1, a(MASK_IDX), '0);
		mon <= 1'b1;
		repeat (300) @(posedge clk);
		cmp({31'h0, irq}, '0, 32'h1);
		bus(1'b0, a(EVENT_IDX), '0);
		cmp(rd, 32'h40, 32'h40);
		for (int i = 0; i < 4; i++) begin
			b = pick[$urandom % 5];
			scen(1, 1, b, 3 + int'($urandom % (b / 2)), 1 + int'($urandom % 2), 1'($urandom), 1'($urandom));
		end
		results();
	end
endmodule : audio_clock_detector_status_bench
